/* logic/xcr_params.svh */
`ifndef XCR_PARAMS_SVH
`define XCR_PARAMS_SVH
// Register numbers within the extended file
`define XCR_REG_INSTR 4'h0
`define XCR_REG_MICRO 4'h1
`define XCR_REG_BUSY_ACTIVE 4'h3
`define XCR_REG_LOCK 4'h4
`define XCR_REG_PARITY 4'h5
`define XCR_REG_SLOT 4'h6
`define XCR_REG_RIGHTS 4'h7
`define XCR_REG_CROSSING 4'h8
`define XCR_REG_CHECKSUM 4'h9
`define XCR_REG_PANEL_ADDR 4'ha
`define XCR_REG_PANEL_DATA 4'hb
// Processor state numbers
`define XCR_EXEC_STATE 3'h4
`define XCR_LAST_DEDICATED 3'h4
`define XCR_LAST_IO_STATE 3'h3
// Field positions of the busy/active word: busy in [15:8], active in [7:0]
`define XCR_BUSY_LSB 8
`define XCR_ACTIVE_LSB 0
// Control-store page length in words
`define XCR_PAGE_WORDS 9'h100
// Reset value (none documented; cleared) and good page checksum value
`define XCR_RESET_WORD 16'h0000
`define XCR_CHECKSUM_GOOD 16'hffff
`endif

/* logic/xcr_pkg.sv */
package xcr_pkg;
   // Instruction kinds presented to the register file
   typedef enum logic [2:0]
   {
      XCR_OP_NONE,
      XCR_OP_READ,
      XCR_OP_WRITE_EXT,
      XCR_OP_WRITE_ANY,
      XCR_OP_SET_BA,
      XCR_OP_CLEAR_BA,
      XCR_OP_EXEC_CALL,
      XCR_OP_IO
   } xcr_op_t;
endpackage

/* logic/xcr_regfile.sv */
`timescale 1ns/1ns
`include "xcr_params.svh"

// What this block does
// - Privileged ops need the state's rights flag
// - Restricted ops only on states zero to four
// - Every input/output op is restricted
// - Executive state reaches all but I/O registers
// - I/O registers exist only for states 0-3
// - Instruction, micro and parity registers are read-only
// - Register 00 holds current instruction word
// - Register 01 holds next micro entry address
// - Register 05 captures last parity fault address
// - Register 06: consecutive bits plus I/O priorities
// - Register 07 holds one rights bit per state
// - Register 08 holds cross-state access target
// - Register 09 accumulates page XOR, good is ones
// - Extended writes, and write-any from state four, clear register 09
// - Limited registers: anyone reads, privileged/executive write
// - Busy bit set means major cycle request
// - Device request may set I/O state busy
// - Exec call sets executive, clears requester
// - Set/clear busy-active touches designated state only
// - Extended write replaces all sixteen bits; on register 09 it clears them
// - Write-any only from executive state four
module xcr_regfile
#(
   parameter int STATES = 8,
   parameter int IO_STATES = 4
)
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Instruction port, one op per cycle
   input wire xcr_pkg::xcr_op_t OP,
   input wire logic [2:0] OP_STATE,
   input wire logic [3:0] OP_REG,
   input wire logic [15:0] OP_WDATA,
   input wire logic [2:0] OP_TARGET,
   input wire logic OP_BUSY_SEL,
   input wire logic OP_ACTIVE_SEL,
   // Per-state instruction capture from the sequencer
   input wire logic INSTR_LOAD,
   input wire logic [15:0] INSTR_WORD,
   input wire logic MICRO_LOAD,
   input wire logic [15:0] MICRO_WORD,
   // Parity fault capture
   input wire logic PARITY_FAULT,
   input wire logic [15:0] PARITY_ADDR,
   // Control-store page scan
   input wire logic SCAN_VALID,
   input wire logic [15:0] SCAN_WORD,
   // Device and panel busy requests, asynchronous pins
   input wire logic [3:0] DEV_BUSY_REQ,
   input wire logic [7:0] PANEL_BUSY_REQ,
   // Results
   output logic [15:0] RD_DATA,
   output logic OP_DONE,
   output logic OP_FAULT,
   output logic [7:0] CYCLE_REQ,
   output logic [15:0] SLOT_GRANT,
   output logic [7:0] RIGHTS,
   output logic PAGE_DONE,
   output logic PAGE_GOOD
);

   typedef struct packed
   {
      logic [STATES-1:0][15:0] instr;
      logic [STATES-1:0][15:0] micro;
      logic [7:0] busy;
      logic [7:0] active;
      logic [15:0] lock;
      logic [15:0] parity;
      logic [15:0] slot;
      logic [15:0] rights;
      logic [15:0] crossing;
      logic [15:0] checksum;
      logic [8:0] scan_cnt;
      logic [15:0] panel_addr;
      logic [15:0] panel_data;
      logic [3:0] dev_s1;
      logic [3:0] dev_s2;
      logic [7:0] pan_s1;
      logic [7:0] pan_s2;
      logic [15:0] rd;
      logic done;
      logic fault;
      logic page_done;
      logic page_good;
   } xcr_state_t;

   xcr_state_t st_r;
   xcr_state_t st_nxt;

   // Pack busy/active into the documented sixteen-bit view
   function automatic logic [15:0] pack_ba(input logic [7:0] b, input logic [7:0] a);
      pack_ba = {b, a};
   endfunction

   // Limited-access common registers
   function automatic logic is_limited(input logic [3:0] r);
      is_limited = (r == `XCR_REG_BUSY_ACTIVE) || (r == `XCR_REG_SLOT) ||
         (r == `XCR_REG_RIGHTS) || (r == `XCR_REG_CROSSING);
   endfunction

   logic priv;
   logic dedicated;
   logic is_exec;
   logic [7:0] tgt_mask;
   logic [7:0] req_mask;
   logic [15:0] rd_val;
   logic rd_ok;
   logic wr_ok;
   logic ck_clear;

   // Access qualification for the issuing state
   always_comb
   begin
      priv = st_r.rights[OP_STATE];
      dedicated = (OP_STATE <= `XCR_LAST_DEDICATED);
      is_exec = (OP_STATE == `XCR_EXEC_STATE);
      tgt_mask = 8'h01 << OP_TARGET;
      req_mask = 8'h01 << OP_STATE;
   end

   // Read multiplexer; instruction and micro registers are per state
   always_comb
   begin
      rd_val = 16'h0000;
      rd_ok = 1'b1;
      if (OP_REG == `XCR_REG_INSTR)
      begin
         rd_val = st_r.instr[OP_STATE];
      end
      else if (OP_REG == `XCR_REG_MICRO)
      begin
         rd_val = st_r.micro[OP_STATE];
      end
      else if (OP_REG == `XCR_REG_BUSY_ACTIVE)
      begin
         rd_val = pack_ba(st_r.busy, st_r.active);
      end
      else if (OP_REG == `XCR_REG_LOCK)
      begin
         rd_val = st_r.lock;
      end
      else if (OP_REG == `XCR_REG_PARITY)
      begin
         rd_val = st_r.parity;
      end
      else if (OP_REG == `XCR_REG_SLOT)
      begin
         rd_val = st_r.slot;
      end
      else if (OP_REG == `XCR_REG_RIGHTS)
      begin
         rd_val = st_r.rights;
      end
      else if (OP_REG == `XCR_REG_CROSSING)
      begin
         rd_val = st_r.crossing;
      end
      else if (OP_REG == `XCR_REG_CHECKSUM)
      begin
         rd_val = st_r.checksum;
      end
      else if (OP_REG == `XCR_REG_PANEL_ADDR)
      begin
         rd_val = st_r.panel_addr;
      end
      else if (OP_REG == `XCR_REG_PANEL_DATA)
      begin
         rd_val = st_r.panel_data;
      end
      else
      begin
         rd_ok = 1'b0; // Unassigned 0C-0F and 02
      end
   end

   // Write permission per register
   always_comb
   begin
      wr_ok = 1'b0;
      if (is_limited(OP_REG))
      begin
         wr_ok = priv || is_exec;
      end
      else if (OP_REG == `XCR_REG_LOCK || OP_REG == `XCR_REG_CHECKSUM ||
               OP_REG == `XCR_REG_PANEL_ADDR || OP_REG == `XCR_REG_PANEL_DATA)
      begin
         wr_ok = 1'b1;
      end
      else
      begin
         wr_ok = 1'b0;
      end
   end

   // Next-state logic for the whole register file
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.fault = 1'b0;
      st_nxt.page_done = 1'b0;
      // Pin synchronisers: first stage feeds only the second
      st_nxt.dev_s1 = DEV_BUSY_REQ;
      st_nxt.dev_s2 = st_r.dev_s1;
      st_nxt.pan_s1 = PANEL_BUSY_REQ;
      st_nxt.pan_s2 = st_r.pan_s1;
      // Sequencer captures
      if (INSTR_LOAD)
      begin
         st_nxt.instr[OP_STATE] = INSTR_WORD;
      end
      if (MICRO_LOAD)
      begin
         st_nxt.micro[OP_STATE] = MICRO_WORD;
      end
      if (PARITY_FAULT)
      begin
         st_nxt.parity = PARITY_ADDR;
      end
      // Software ops
      case (OP)
         xcr_pkg::XCR_OP_READ:
         begin
            st_nxt.done = 1'b1;
            st_nxt.fault = ~rd_ok;
            st_nxt.rd = rd_val;
         end
         xcr_pkg::XCR_OP_WRITE_EXT, xcr_pkg::XCR_OP_WRITE_ANY:
         begin
            // Write-any is the executive's; both also need the register's write permission
            // Extended write leans on the per-register permission alone, so
            // the limited registers still need rights or the executive
            if ((OP == xcr_pkg::XCR_OP_WRITE_ANY && !is_exec) || !wr_ok)
            begin
               st_nxt.fault = 1'b1;
            end
            else if (OP_REG == `XCR_REG_BUSY_ACTIVE)
            begin
               st_nxt.busy = OP_WDATA[`XCR_BUSY_LSB +: 8];
               st_nxt.active = OP_WDATA[`XCR_ACTIVE_LSB +: 8];
            end
            else if (OP_REG == `XCR_REG_LOCK)
            begin
               st_nxt.lock = OP_WDATA;
            end
            else if (OP_REG == `XCR_REG_SLOT)
            begin
               st_nxt.slot = OP_WDATA;
            end
            else if (OP_REG == `XCR_REG_RIGHTS)
            begin
               st_nxt.rights = OP_WDATA;
            end
            else if (OP_REG == `XCR_REG_CROSSING)
            begin
               st_nxt.crossing = OP_WDATA;
            end
            else if (OP_REG == `XCR_REG_CHECKSUM)
            begin
               st_nxt.checksum = `XCR_RESET_WORD;
               st_nxt.scan_cnt = 9'h000;
            end
            else if (OP_REG == `XCR_REG_PANEL_ADDR)
            begin
               st_nxt.panel_addr = OP_WDATA;
            end
            else
            begin
               st_nxt.panel_data = OP_WDATA;
            end
            st_nxt.done = 1'b1;
         end
         xcr_pkg::XCR_OP_SET_BA:
         begin
            if (!priv)
            begin
               st_nxt.fault = 1'b1;
            end
            else
            begin
               // Only the designated state's bits move
               if (OP_BUSY_SEL) st_nxt.busy = st_r.busy | tgt_mask;
               if (OP_ACTIVE_SEL) st_nxt.active = st_r.active | tgt_mask;
            end
            st_nxt.done = 1'b1;
         end
         xcr_pkg::XCR_OP_CLEAR_BA:
         begin
            if (!priv)
            begin
               st_nxt.fault = 1'b1;
            end
            else
            begin
               if (OP_BUSY_SEL) st_nxt.busy = st_r.busy & ~tgt_mask;
               if (OP_ACTIVE_SEL) st_nxt.active = st_r.active & ~tgt_mask;
            end
            st_nxt.done = 1'b1;
         end
         xcr_pkg::XCR_OP_EXEC_CALL:
         begin
            // Requester cleared first so a call from the executive keeps it set
            st_nxt.busy = (st_r.busy & ~req_mask) | (8'h01 << `XCR_EXEC_STATE);
            st_nxt.active = (st_r.active & ~req_mask) | (8'h01 << `XCR_EXEC_STATE);
            st_nxt.done = 1'b1;
         end
         xcr_pkg::XCR_OP_IO:
         begin
            // I/O registers live in the I/O engines; only the state check is here
            st_nxt.fault = !dedicated || (OP_STATE > `XCR_LAST_IO_STATE);
            st_nxt.done = 1'b1;
         end
         default:
         begin
         end
      endcase
      // Hardware busy requests win over any software clear in the same cycle
      st_nxt.busy[IO_STATES-1:0] = st_nxt.busy[IO_STATES-1:0] | st_r.dev_s2;
      st_nxt.busy = st_nxt.busy | st_r.pan_s2;
      // Control-store page scan; a clear that really lands wins over a scan word,
      // while a refused write or any other op leaves the scan running
      ck_clear = (OP == xcr_pkg::XCR_OP_WRITE_EXT || OP == xcr_pkg::XCR_OP_WRITE_ANY) &&
         OP_REG == `XCR_REG_CHECKSUM && !st_nxt.fault;
      if (SCAN_VALID && !ck_clear)
      begin
         st_nxt.checksum = st_r.checksum ^ SCAN_WORD;
         if (st_r.scan_cnt == `XCR_PAGE_WORDS - 9'h001)
         begin
            st_nxt.scan_cnt = 9'h000;
            st_nxt.page_done = 1'b1;
            st_nxt.page_good = ((st_r.checksum ^ SCAN_WORD) == `XCR_CHECKSUM_GOOD);
         end
         else
         begin
            st_nxt.scan_cnt = st_r.scan_cnt + 9'h001;
         end
      end
   end

   // State register
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs from flip-flops
   assign RD_DATA = st_r.rd;
   assign OP_DONE = st_r.done;
   assign OP_FAULT = st_r.fault;
   assign CYCLE_REQ = st_r.busy;
   assign SLOT_GRANT = st_r.slot;
   assign RIGHTS = st_r.rights[7:0];
   assign PAGE_DONE = st_r.page_done;
   assign PAGE_GOOD = st_r.page_good;

endmodule

/* verif/xcr_regfile_chk.sv */
`timescale 1ns/1ns
module xcr_regfile_chk
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // Instruction port
   input wire xcr_pkg::xcr_op_t OP,
   input wire logic [2:0] OP_STATE,
   input wire logic [3:0] OP_REG,
   input wire logic [15:0] OP_WDATA,
   input wire logic [2:0] OP_TARGET,
   input wire logic OP_BUSY_SEL,
   input wire logic [3:0] DEV_BUSY_REQ,
   // Results
   input wire logic OP_FAULT,
   input wire logic [7:0] CYCLE_REQ,
   input wire logic [7:0] RIGHTS
);
   logic [7:0] wlow_r;
   logic [2:0] tgt_r;
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);
   // Request fields kept one cycle, since the answer lands a cycle later
   always_ff @(posedge CORE_CLK)
   begin
      wlow_r <= OP_WDATA[7:0];
      tgt_r <= OP_TARGET;
   end
   // Write aimed at a hardware-owned register
   sequence s_ro_write;
      (OP == xcr_pkg::XCR_OP_WRITE_EXT || OP == xcr_pkg::XCR_OP_WRITE_ANY)
         && OP_REG inside {4'h0, 4'h1, 4'h5};
   endsequence
   // Device line rising ahead of the synchroniser
   sequence s_dev_rise;
      $rose(DEV_BUSY_REQ[0]);
   endsequence
   a_ro_write_refused: assert property (s_ro_write |=> OP_FAULT)
      else $error("read-only write taken");
   a_any_needs_exec: assert property (
      OP == xcr_pkg::XCR_OP_WRITE_ANY && OP_STATE != 3'h4 |=> OP_FAULT)
      else $error("write-any taken off exec");
   a_io_restricted: assert property (
      OP == xcr_pkg::XCR_OP_IO && OP_STATE > 3'h4 |=> OP_FAULT)
      else $error("io op taken off dedicated");
   a_set_needs_rights: assert property (
      OP == xcr_pkg::XCR_OP_SET_BA && !RIGHTS[OP_STATE] |=> OP_FAULT)
      else $error("set taken without rights");
   a_set_busy_lands: assert property (
      OP == xcr_pkg::XCR_OP_SET_BA && RIGHTS[OP_STATE] && OP_BUSY_SEL |=> CYCLE_REQ[tgt_r])
      else $error("busy not set");
   a_exec_call_busy: assert property (
      OP == xcr_pkg::XCR_OP_EXEC_CALL && OP_STATE != 3'h4 |=> CYCLE_REQ[4])
      else $error("exec busy not set");
   a_rights_written: assert property (
      OP == xcr_pkg::XCR_OP_WRITE_EXT && OP_STATE == 3'h4 && OP_REG == 4'h7
      |=> RIGHTS == wlow_r)
      else $error("rights not written");
   a_limited_refused: assert property (
      OP == xcr_pkg::XCR_OP_WRITE_EXT && OP_REG inside {4'h3, 4'h6, 4'h7, 4'h8}
      && !RIGHTS[OP_STATE] && OP_STATE != 3'h4 |=> OP_FAULT)
      else $error("limited write taken");
   a_dev_busy_sync: assert property (s_dev_rise |-> ##[1:4] CYCLE_REQ[0])
      else $error("device busy lost");
   a_io_state_only: assert property (
      OP == xcr_pkg::XCR_OP_IO && OP_STATE > 3'h3 |=> OP_FAULT)
      else $error("io op taken off io state");
endmodule

/* verif/xcr_regfile_tb_top.sv */
`timescale 1ns/1ns
module xcr_regfile_tb_top;
   localparam xcr_pkg::xcr_op_t WX = xcr_pkg::XCR_OP_WRITE_EXT;
   localparam xcr_pkg::xcr_op_t WA = xcr_pkg::XCR_OP_WRITE_ANY;
   localparam xcr_pkg::xcr_op_t RD = xcr_pkg::XCR_OP_READ;
   // Design side signals
   logic CORE_CLK, RESETN, OP_BUSY_SEL, OP_ACTIVE_SEL, INSTR_LOAD, MICRO_LOAD;
   logic PARITY_FAULT, SCAN_VALID, OP_DONE, OP_FAULT, PAGE_DONE, PAGE_GOOD;
   xcr_pkg::xcr_op_t OP;
   logic [2:0] OP_STATE, OP_TARGET, s;
   logic [3:0] OP_REG, DEV_BUSY_REQ;
   logic [15:0] OP_WDATA, INSTR_WORD, MICRO_WORD, PARITY_ADDR, SCAN_WORD, RD_DATA;
   logic [15:0] SLOT_GRANT, d, ba_exp;
   logic [7:0] PANEL_BUSY_REQ, CYCLE_REQ, RIGHTS;
   logic [31:0] seed = 32'h962c_5371;
   logic [3:0] lim [4] = '{4'h3, 4'h6, 4'h7, 4'h8};
   logic [3:0] ro [3] = '{4'h0, 4'h1, 4'h5};
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int i;
   xcr_regfile dut
   (
      .CORE_CLK(CORE_CLK), .RESETN(RESETN), .OP(OP), .OP_STATE(OP_STATE), .OP_REG(OP_REG),
      .OP_WDATA(OP_WDATA), .OP_TARGET(OP_TARGET), .OP_BUSY_SEL(OP_BUSY_SEL),
      .OP_ACTIVE_SEL(OP_ACTIVE_SEL), .INSTR_LOAD(INSTR_LOAD), .INSTR_WORD(INSTR_WORD),
      .MICRO_LOAD(MICRO_LOAD), .MICRO_WORD(MICRO_WORD), .PARITY_FAULT(PARITY_FAULT),
      .PARITY_ADDR(PARITY_ADDR), .SCAN_VALID(SCAN_VALID), .SCAN_WORD(SCAN_WORD),
      .DEV_BUSY_REQ(DEV_BUSY_REQ), .PANEL_BUSY_REQ(PANEL_BUSY_REQ), .RD_DATA(RD_DATA),
      .OP_DONE(OP_DONE), .OP_FAULT(OP_FAULT), .CYCLE_REQ(CYCLE_REQ),
      .SLOT_GRANT(SLOT_GRANT), .RIGHTS(RIGHTS), .PAGE_DONE(PAGE_DONE), .PAGE_GOOD(PAGE_GOOD)
   );
   // 25 MHz core clock
   initial
   begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end
   // Hang guard, well above the roughly 760 cycles the run needs
   always @(posedge CORE_CLK)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Many shifts per draw so neighbouring values are not plain shifts of each other
   function automatic logic [15:0] rnd();
      repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction
   function automatic logic [15:0] ecall(input logic [15:0] w, input logic [2:0] st);
      return (w & ~(16'h0101 << st)) | 16'h1010;
   endfunction
   // One instruction; the answer stands only in the following cycle
   task automatic op(input xcr_pkg::xcr_op_t k, input logic [2:0] st, input logic [3:0] r,
      input logic [15:0] wd, input logic f, input logic [2:0] t = 3'h0,
      input logic [1:0] ba = 2'h0);
      @(posedge CORE_CLK);
      OP <= k;
      OP_STATE <= st;
      OP_REG <= r;
      OP_WDATA <= wd;
      OP_TARGET <= t;
      {OP_BUSY_SEL, OP_ACTIVE_SEL} <= ba;
      @(posedge CORE_CLK);
      OP <= xcr_pkg::XCR_OP_NONE;
      #1;
      chk(16'(OP_DONE), 16'h0001);
      chk(16'(OP_FAULT), 16'(f));
   endtask
   task automatic rd(input logic [2:0] st, input logic [3:0] r, input logic [15:0] e,
      input logic f = 1'b0);
      op(RD, st, r, 16'h0000, f);
      if (!f)
         chk(RD_DATA, e);
   endtask
   // One control-store page; the last word makes it fold to all ones, then
   // the spoil bits flip the result so a stuck good flag is caught
   task automatic page(input logic [15:0] spoil);
      logic [15:0] w;
      logic [15:0] a;
      int k;
      a = 16'hffff ^ spoil;
      for (k = 0; k < 256; k++)
      begin
         w = (k == 255) ? a : rnd();
         a = a ^ w;
         @(posedge CORE_CLK);
         SCAN_VALID <= 1'b1;
         SCAN_WORD <= w;
      end
      @(posedge CORE_CLK);
      SCAN_VALID <= 1'b0;
      #1;
      chk(16'(PAGE_DONE), 16'h0001);
      chk(16'(PAGE_GOOD), 16'(spoil == 16'h0000));
   endtask
   // Main sequence
   initial
   begin
      RESETN = 1'b0;
      OP = xcr_pkg::XCR_OP_NONE;
      {OP_STATE, OP_TARGET, OP_REG, DEV_BUSY_REQ, PANEL_BUSY_REQ} = '0;
      {OP_WDATA, INSTR_WORD, MICRO_WORD, PARITY_ADDR, SCAN_WORD} = '0;
      {OP_BUSY_SEL, OP_ACTIVE_SEL, INSTR_LOAD, MICRO_LOAD, PARITY_FAULT, SCAN_VALID} = '0;
      repeat (12) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      op(WX, 3'h4, 4'h7, 16'h0006, 1'b0);
      chk(16'(RIGHTS), 16'h0006);
      rd(3'h5, 4'h7, 16'h0006);
      foreach (lim[j])
         op(WX, 3'h7, lim[j], 16'hffff, 1'b1);
      for (i = 0; i < 8; i++)
      begin
         d = rnd();
         op(WX, 3'h1, 4'h3, d, 1'b0);
         rd(3'h0, 4'h3, d);
         chk(16'(CYCLE_REQ), 16'(d[15:8]));
         op(WA, 3'h2, 4'h3, ~d, 1'b1);
         op(WA, 3'h4, 4'h3, ~d, 1'b0);
         rd(3'h6, 4'h3, ~d);
         s = d[2:0];
         ba_exp = ~d | (16'h0101 << s);
         op(xcr_pkg::XCR_OP_SET_BA, 3'h2, 4'h3, 16'h0000, 1'b0, s, 2'h3);
         op(xcr_pkg::XCR_OP_SET_BA, 3'h0, 4'h3, 16'h0000, 1'b1, s, 2'h3);
         s = d[5:3];
         ba_exp = ba_exp & ~(16'h0100 << s);
         op(xcr_pkg::XCR_OP_CLEAR_BA, 3'h1, 4'h3, 16'h0000, 1'b0, s, 2'h2);
         s = (d[8:6] == 3'h4) ? 3'h7 : d[8:6];
         ba_exp = ecall(ba_exp, s);
         op(xcr_pkg::XCR_OP_EXEC_CALL, s, 4'h3, 16'h0000, 1'b0);
         rd(3'h7, 4'h3, ba_exp);
      end
      op(WX, 3'h4, 4'h6, d, 1'b0);
      chk(SLOT_GRANT, d);
      op(WX, 3'h2, 4'h8, ~d, 1'b0);
      rd(3'h3, 4'h8, ~d);
      op(WX, 3'h7, 4'h4, d, 1'b0);
      rd(3'h5, 4'h4, d);
      for (i = 0; i < 8; i++)
         op(xcr_pkg::XCR_OP_IO, i[2:0], 4'h0, 16'h0000, i > 3);
      foreach (ro[j])
         op(WX, 3'h4, ro[j], 16'h1234, 1'b1);
      rd(3'h4, 4'hc, 16'h0000, 1'b1);
      // Sequencer and parity captures in one cycle
      @(posedge CORE_CLK);
      {INSTR_LOAD, MICRO_LOAD, PARITY_FAULT} <= 3'h7;
      {INSTR_WORD, MICRO_WORD, PARITY_ADDR} <= {d, ~d, d ^ 16'h5a5a};
      OP_STATE <= 3'h3;
      @(posedge CORE_CLK);
      {INSTR_LOAD, MICRO_LOAD, PARITY_FAULT} <= 3'h0;
      rd(3'h3, 4'h0, d);
      rd(3'h2, 4'h0, 16'h0000);
      rd(3'h3, 4'h1, ~d);
      rd(3'h0, 4'h5, d ^ 16'h5a5a);
      // A good page leaves all ones, a write clears them, then a spoiled page
      page(16'h0000);
      rd(3'h6, 4'h9, 16'hffff);
      op(WX, 3'h6, 4'h9, d, 1'b0);
      rd(3'h6, 4'h9, 16'h0000);
      page(16'h0010);
      op(WX, 3'h1, 4'h3, 16'h0000, 1'b0);
      @(posedge CORE_CLK);
      DEV_BUSY_REQ <= 4'h5;
      PANEL_BUSY_REQ <= 8'h80;
      repeat (5) @(posedge CORE_CLK);
      #1;
      chk(16'(CYCLE_REQ), 16'h0085);
      tally_and_finish();
   end
endmodule
bind xcr_regfile xcr_regfile_chk u_chk
(
   .CORE_CLK(CORE_CLK), .RESETN(RESETN), .OP(OP), .OP_STATE(OP_STATE), .OP_REG(OP_REG),
   .OP_WDATA(OP_WDATA), .OP_TARGET(OP_TARGET), .OP_BUSY_SEL(OP_BUSY_SEL),
   .DEV_BUSY_REQ(DEV_BUSY_REQ), .OP_FAULT(OP_FAULT), .CYCLE_REQ(CYCLE_REQ), .RIGHTS(RIGHTS)
);
